// [legacy_mode_pkg.sv]
package legacy_mode_pkg;

   // ==========================================================
   // mode field encodings
   // ==========================================================
   localparam logic [4:0] MODE_USER_LEGACY = 5'h00;
   localparam logic [4:0] MODE_FIQ_LEGACY = 5'h01;
   localparam logic [4:0] MODE_IRQ_LEGACY = 5'h02;
   localparam logic [4:0] MODE_SVC_LEGACY = 5'h03;
   localparam logic [4:0] MODE_USER32 = 5'h10;
   localparam logic [4:0] MODE_FIQ32 = 5'h11;
   localparam logic [4:0] MODE_IRQ32 = 5'h12;
   localparam logic [4:0] MODE_SVC32 = 5'h13;
   localparam logic [4:0] MODE_ABT32 = 5'h17;
   localparam logic [4:0] MODE_UND32 = 5'h1B;
   localparam logic [4:0] RESET_MODE = MODE_SVC32;

   // ==========================================================
   // field positions
   // ==========================================================
   localparam int MODE_LSB = 0;
   localparam int MODE_MSB = 4;
   localparam int LEGACY_BIT = 4;
   localparam int FIQ_DIS_BIT = 6;
   localparam int IRQ_DIS_BIT = 7;
   localparam int MERGE_FIQ_BIT = 26;
   localparam int MERGE_IRQ_BIT = 27;
   localparam int FLAGS_LSB = 28;
   localparam int PC_MSB = 25;
   localparam int PC_LSB = 2;
   localparam logic [31:0] RESET_STATUS = 32'h000000D3;

   // ==========================================================
   // exception vector region and legacy space
   // ==========================================================
   localparam logic [31:0] VECTOR_LO = 32'h00000000;
   localparam logic [31:0] VECTOR_HI = 32'h0000001F;

   // ==========================================================
   // register bus map
   // ==========================================================
   localparam logic [3:0] ADDR_CTRL = 4'h0;
   localparam logic [3:0] ADDR_STATUS_WORD = 4'h1;
   localparam logic [3:0] ADDR_SAVED_WORD = 4'h2;
   localparam logic [3:0] ADDR_LINK = 4'h3;
   localparam logic [3:0] ADDR_PC_VIEW = 4'h4;
   localparam logic [3:0] ADDR_EVENTS = 4'h5;
   localparam logic [3:0] ADDR_MASK = 4'h6;
   localparam logic [3:0] ADDR_BANK = 4'h7;
   localparam int CTRL_CFG26_BIT = 0;
   localparam int EV_ADDR_EXC = 0;
   localparam int EV_VEC_ABORT = 1;
   localparam int EV_EXCEPTION = 2;
   localparam int EV_BARRIER = 3;
   localparam int EV_MODE_ERR = 4;
   localparam int EV_WIDTH = 5;

   // ==========================================================
   // request carriers
   // ==========================================================
   typedef struct packed {
      logic valid;
      logic write;
      logic [31:0] addr;
   } mem_req_t;

   typedef struct packed {
      logic valid;
      logic to_saved;
      logic [31:0] data;
   } status_write_t;

   typedef struct packed {
      logic valid;
      logic [4:0] target_mode;
      logic is_trap;
      logic [31:0] return_pc;
   } exc_req_t;

endpackage

// [legacy_bank_select.sv]
`timescale 1ns/100ps
`default_nettype none
// ============================================================
// bank selector: which banked copy a mode uses
// ============================================================
module legacy_bank_select
   import legacy_mode_pkg::*;
(
   input wire logic [4:0] mode,
   output logic [1:0] bank_r13_14,
   output logic fiq_bank_r8_12,
   output logic has_saved
);
   // per-mode banking
   // legacy user banks nothing; fiq banks 8..14; irq and svc 13..14
   always_comb begin
      bank_r13_14 = 2'h0;
      fiq_bank_r8_12 = 1'b0;
      has_saved = 1'b1;
      unique case (mode[3:0])
         MODE_FIQ_LEGACY[3:0]: begin
            bank_r13_14 = 2'h1;
            fiq_bank_r8_12 = 1'b1;
         end
         MODE_IRQ_LEGACY[3:0]: bank_r13_14 = 2'h2;
         MODE_SVC_LEGACY[3:0]: bank_r13_14 = 2'h3;
         default: has_saved = (mode != MODE_USER32) && mode[LEGACY_BIT];
      endcase
      if (mode == MODE_USER_LEGACY) begin
         has_saved = 1'b0;
      end
   end
endmodule
`default_nettype wire

// [legacy_26bit_mode_control.sv]
// Operation
// - 32-bit config, legacy mode: no address exception
// - 26-bit config still raises address exceptions
// - status moves work in legacy modes
// - exceptions switch to matching 32-bit mode
// - saved link holds program counter only
// - legacy writes to vectors abort, blocked
// - I at 27, F at 26 in PC
// - mode codes 0..3 enter legacy modes
// - legacy banking: fiq 8-14, irq/svc 13-14
// - privileged legacy code may enter 32-bit
// - software trap performs instruction barrier
// - both barriers flush everything
//
// Decided for this implementation: strobed register access and the register offsets.
`timescale 1ns/100ps
`default_nettype none
module legacy_26bit_mode_control
   import legacy_mode_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire mem_req_t mem_req,
   input wire status_write_t status_wr,
   input wire exc_req_t exc_req,
   input wire logic barrier_req,
   input wire logic ranged_barrier_req,
   input wire logic [3:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   output logic [31:0] reg_rdata,
   output logic mem_pass,
   output logic data_abort,
   output logic address_exception,
   output logic stream_flush,
   output logic [31:0] link_register,
   output logic [31:0] current_status_word,
   output logic [31:0] saved_status_word,
   output logic [31:0] program_counter_register,
   output logic [4:0] active_mode,
   output logic irq
);
   // ============================================================
   // state
   // ============================================================
   logic cfg26, next_cfg26;
   logic [31:0] status, next_status;
   logic [31:0] saved_bank [4];
   logic [31:0] next_saved_bank [4];
   logic [31:0] link, next_link;
   logic [31:0] pc, next_pc;
   logic [EV_WIDTH-1:0] events, next_events;
   logic [EV_WIDTH-1:0] mask, next_mask;
   logic [31:0] rdata, next_rdata;
   logic pass_q, abort_q, aexc_q, flush_q;
   logic next_pass, next_abort, next_aexc, next_flush;
   logic irq_q;
   logic [1:0] bank_r13_14;
   logic fiq_bank;
   logic has_saved;
   logic [1:0] saved_idx;
   logic [4:0] cur_mode;
   logic legacy;
   logic privileged;
   logic in_vectors;
   logic out_of_legacy;
   logic [EV_WIDTH-1:0] ev_set;
   // registered copies of the two computed views
   logic [31:0] saved_q;
   logic [31:0] pc_view_q;
   logic [1:0] next_bank_idx;
   logic [4:0] wr_mode;
   logic wr_mode_ok;

   assign cur_mode = status[MODE_MSB:MODE_LSB];
   assign legacy = ~cur_mode[LEGACY_BIT];
   assign privileged = (cur_mode != MODE_USER_LEGACY) &&
      (cur_mode != MODE_USER32);

   legacy_bank_select u_bank (
      .mode(cur_mode),
      .bank_r13_14(bank_r13_14),
      .fiq_bank_r8_12(fiq_bank),
      .has_saved(has_saved)
   );

   // bank of the mode that the next edge makes current, so the saved
   // word output can come straight from a flip-flop
   legacy_bank_select u_next_bank (
      .mode(next_status[MODE_MSB:MODE_LSB]),
      .bank_r13_14(next_bank_idx),
      .fiq_bank_r8_12(),
      .has_saved()
   );

   // saved word slot: legacy modes share their 32-bit twin's copy
   assign saved_idx = bank_r13_14;

   // ============================================================
   // memory access checking
   // ============================================================
   assign in_vectors = (mem_req.addr >= VECTOR_LO) &&
      (mem_req.addr <= VECTOR_HI);
   // legacy space is 26 address bits; anything above is out of range
   assign out_of_legacy = |mem_req.addr[31:PC_MSB+1];

   // decoded mode written by a move-to-status
   assign wr_mode = status_wr.data[MODE_MSB:MODE_LSB];
   always_comb begin
      wr_mode_ok = 1'b0;
      unique case (wr_mode)
         MODE_USER_LEGACY, MODE_FIQ_LEGACY, MODE_IRQ_LEGACY,
         MODE_SVC_LEGACY, MODE_USER32, MODE_FIQ32, MODE_IRQ32,
         MODE_SVC32, MODE_ABT32, MODE_UND32: wr_mode_ok = 1'b1;
         default: wr_mode_ok = 1'b0;
      endcase
   end

   // one process computes all next values of the control state
   always_comb begin
      next_cfg26 = cfg26;
      next_status = status;
      next_saved_bank = saved_bank;
      next_link = link;
      next_pc = pc;
      next_mask = mask;
      next_rdata = 32'h00000000;
      next_pass = 1'b0;
      next_abort = 1'b0;
      next_aexc = 1'b0;
      next_flush = 1'b0;
      ev_set = '0;

      if (mem_req.valid) begin
         if (mem_req.write && legacy && in_vectors) begin
            next_abort = 1'b1;
            ev_set[EV_VEC_ABORT] = 1'b1;
         end else if (legacy && cfg26 && out_of_legacy) begin
            // address exception kept
            // legacy space overflow only faults in the 26-bit config
            next_aexc = 1'b1;
            ev_set[EV_ADDR_EXC] = 1'b1;
         end else begin
            next_pass = 1'b1;
         end
      end

      if (status_wr.valid) begin
         if (status_wr.to_saved) begin
            if (has_saved) begin
               next_saved_bank[saved_idx] = status_wr.data;
            end
         end else if (!privileged) begin
            // user may only touch the flags
            next_status[31:FLAGS_LSB] = status_wr.data[31:FLAGS_LSB];
         end else if (wr_mode_ok) begin
            next_status = status_wr.data;
         end else begin
            ev_set[EV_MODE_ERR] = 1'b1;
         end
      end

      // an exception overrides the mode field of a status move in the same cycle; the move's other bits still land
      if (exc_req.valid) begin
         next_status[MODE_MSB:MODE_LSB] = exc_req.target_mode;
         next_status[LEGACY_BIT] = 1'b1;
         next_saved_bank[exc_req.target_mode[1:0]] = status;
         next_link = legacy ?
            {6'h00, exc_req.return_pc[PC_MSB:PC_LSB], 2'h0} :
            exc_req.return_pc;
         next_pc = exc_req.return_pc;
         ev_set[EV_EXCEPTION] = 1'b1;
         if (exc_req.is_trap) begin
            next_flush = 1'b1;
            ev_set[EV_BARRIER] = 1'b1;
         end
      end

      if (barrier_req || ranged_barrier_req) begin
         next_flush = 1'b1;
         ev_set[EV_BARRIER] = 1'b1;
      end

      // register bus writes
      if (reg_write) begin
         unique case (reg_addr)
            ADDR_CTRL: next_cfg26 = reg_wdata[CTRL_CFG26_BIT];
            ADDR_MASK: next_mask = reg_wdata[EV_WIDTH-1:0];
            ADDR_PC_VIEW: next_pc = reg_wdata;
            default: ;
         endcase
      end

      // register bus reads, answered in the following cycle
      if (reg_read) begin
         unique case (reg_addr)
            ADDR_CTRL: next_rdata[CTRL_CFG26_BIT] = cfg26;
            ADDR_STATUS_WORD: next_rdata = status;
            ADDR_SAVED_WORD: next_rdata = saved_bank[saved_idx];
            ADDR_LINK: next_rdata = link;
            ADDR_PC_VIEW: next_rdata = merged_view(pc, status);
            ADDR_EVENTS: next_rdata[EV_WIDTH-1:0] = events;
            ADDR_MASK: next_rdata[EV_WIDTH-1:0] = mask;
            ADDR_BANK: next_rdata = {27'h0000000, has_saved,
               fiq_bank, bank_r13_14, legacy};
            default: next_rdata = 32'h00000000;
         endcase
      end

      // sticky events: set wins over a write-one clear
      next_events = events;
      if (reg_write && reg_addr == ADDR_EVENTS) begin
         next_events = events & ~reg_wdata[EV_WIDTH-1:0];
      end
      next_events = next_events | ev_set;
   end

   // ============================================================
   // merged program counter view
   // ============================================================
   // I bit 27, F bit 26
   function automatic logic [31:0] merged_view(
      input logic [31:0] p,
      input logic [31:0] s
   );
      logic [31:0] v;
      v = p;
      if (!s[LEGACY_BIT]) begin
         v[31:FLAGS_LSB] = s[31:FLAGS_LSB];
         v[MERGE_IRQ_BIT] = s[IRQ_DIS_BIT];
         v[MERGE_FIQ_BIT] = s[FIQ_DIS_BIT];
         v[1:0] = s[1:0];
      end
      merged_view = v;
   endfunction

   // ============================================================
   // registers
   // ============================================================
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         cfg26 <= 1'b0;
         status <= RESET_STATUS;
         for (int i = 0; i < 4; i++) begin
            saved_bank[i] <= 32'h00000000;
         end
         link <= 32'h00000000;
         pc <= 32'h00000000;
         events <= '0;
         mask <= '0;
         rdata <= 32'h00000000;
         pass_q <= 1'b0;
         abort_q <= 1'b0;
         aexc_q <= 1'b0;
         flush_q <= 1'b0;
         irq_q <= 1'b0;
         saved_q <= 32'h00000000;
         pc_view_q <= 32'h00000000;
      end else begin
         cfg26 <= next_cfg26;
         status <= next_status;
         saved_bank <= next_saved_bank;
         link <= next_link;
         pc <= next_pc;
         events <= next_events;
         mask <= next_mask;
         rdata <= next_rdata;
         pass_q <= next_pass;
         abort_q <= next_abort;
         aexc_q <= next_aexc;
         flush_q <= next_flush;
         irq_q <= |(next_events & next_mask);
         saved_q <= next_saved_bank[next_bank_idx];
         pc_view_q <= merged_view(next_pc, next_status);
      end
   end

   // outputs straight from flip-flops
   assign reg_rdata = rdata;
   assign mem_pass = pass_q;
   assign data_abort = abort_q;
   assign address_exception = aexc_q;
   assign stream_flush = flush_q;
   assign link_register = link;
   assign current_status_word = status;
   assign saved_status_word = saved_q;
   assign program_counter_register = pc_view_q;
   assign active_mode = status[MODE_MSB:MODE_LSB];
   assign irq = irq_q;
endmodule
`default_nettype wire

// [legacy_mode_chk.sv]
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// checker on the top ports
// ==========================================================
module legacy_mode_chk
   import legacy_mode_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire mem_req_t mem_req,
   input wire status_write_t status_wr,
   input wire exc_req_t exc_req,
   input wire logic barrier_req,
   input wire logic ranged_barrier_req,
   input wire logic [3:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   input wire logic [31:0] reg_rdata,
   input wire logic mem_pass,
   input wire logic data_abort,
   input wire logic address_exception,
   input wire logic stream_flush,
   input wire logic [31:0] link_register,
   input wire logic [31:0] current_status_word,
   input wire logic [31:0] saved_status_word,
   input wire logic [31:0] program_counter_register,
   input wire logic [4:0] active_mode,
   input wire logic irq
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   // bit4 clear means a 26-bit mode
   wire legacy = !current_status_word[LEGACY_BIT];
   a_vec_write_abort: assert property (
      mem_req.valid && mem_req.write && legacy && mem_req.addr <= VECTOR_HI
      |=> data_abort && !mem_pass) else $error("vector write passed");
   a_vec_write_ok: assert property (
      mem_req.valid && mem_req.write && !legacy
      |=> mem_pass && !data_abort) else $error("32-bit write refused");
   a_addr_exc_cause: assert property (
      address_exception |-> $past(mem_req.valid && legacy &&
      mem_req.addr[31:26] != 6'h00)) else $error("stray address exception");
   // one answer per request
   a_one_answer: assert property (
      mem_req.valid |=> $onehot({mem_pass, data_abort, address_exception}))
      else $error("answer count wrong");
   a_exc_mode32: assert property (
      exc_req.valid |=> active_mode == ($past(exc_req.target_mode) | 5'h10))
      else $error("exception mode wrong");
   a_link_pc_only: assert property (
      exc_req.valid && legacy |=>
      link_register == ($past(exc_req.return_pc) & 32'h03FFFFFC))
      else $error("link carries status bits");
   a_flush_cause: assert property (
      barrier_req || ranged_barrier_req || (exc_req.valid && exc_req.is_trap)
      |=> stream_flush) else $error("no flush");
   a_pc_merge: assert property (
      legacy |-> program_counter_register[27:26] == current_status_word[7:6])
      else $error("merged bits wrong");
   a_mode_change: assert property (
      status_wr.valid && !status_wr.to_saved && !exc_req.valid &&
      active_mode[3:0] != 4'h0 && status_wr.data[4:0] inside
      {[MODE_USER_LEGACY:MODE_SVC_LEGACY], [MODE_USER32:MODE_SVC32]}
      |=> active_mode == $past(status_wr.data[4:0]))
      else $error("mode not entered");
endmodule
`default_nettype wire

// [legacy_mmu_model.sv]
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// external memory manager model
// ==========================================================
module legacy_mmu_model
   import legacy_mode_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire mem_req_t mem_req,
   output logic ext_abort
);
   logic next_ext_abort;
   always_comb begin
      next_ext_abort = mem_req.valid && (mem_req.addr[31:26] != 6'h00);
   end
   // registered so it lines up with the core's own answer
   always_ff @(posedge sys_clk) begin
      if (!rst_n) ext_abort <= 1'b0;
      else ext_abort <= next_ext_abort;
   end
endmodule
`default_nettype wire

// [test_legacy_26bit_mode_control.sv]
`timescale 1ns/100ps
`default_nettype none
module test_legacy_26bit_mode_control
   import legacy_mode_pkg::*;
;
   logic sys_clk = 1'b0, rst_n = 1'b0, barrier_req = 1'b0;
   logic ranged_barrier_req = 1'b0, reg_write = 1'b0, reg_read = 1'b0;
   logic [3:0] reg_addr = 4'h0;
   logic [31:0] reg_wdata = 32'h0, reg_rdata, link_register, rd;
   logic [31:0] current_status_word, saved_status_word, pc_view;
   mem_req_t mem_req = '0;
   status_write_t status_wr = '0;
   exc_req_t exc_req = '0;
   logic mem_pass, data_abort, address_exception, stream_flush, irq;
   logic ext_abort;
   logic [4:0] active_mode, m;
   int mismatches = 0, n_tests = 0;
   always #4 sys_clk = ~sys_clk;
   legacy_26bit_mode_control dut (.sys_clk(sys_clk), .rst_n(rst_n),
      .mem_req(mem_req), .status_wr(status_wr), .exc_req(exc_req),
      .barrier_req(barrier_req), .ranged_barrier_req(ranged_barrier_req),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
      .reg_read(reg_read), .reg_rdata(reg_rdata), .mem_pass(mem_pass),
      .data_abort(data_abort), .address_exception(address_exception),
      .stream_flush(stream_flush), .link_register(link_register),
      .current_status_word(current_status_word),
      .saved_status_word(saved_status_word),
      .program_counter_register(pc_view), .active_mode(active_mode),
      .irq(irq));
   legacy_mmu_model mmu (.sys_clk(sys_clk), .rst_n(rst_n),
      .mem_req(mem_req), .ext_abort(ext_abort));
   // ==========================================================
   // access tasks
   // ==========================================================
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_write <= 1'b1;
      @(posedge sys_clk);
      reg_write <= 1'b0;
   endtask
   // read data stand only in the cycle after the strobe
   task automatic reg_rd(input logic [3:0] a);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge sys_clk);
      reg_read <= 1'b0;
      #1 rd = reg_rdata;
   endtask
   // answer order: external abort, pass, vector abort, address exception
   task automatic mem_chk(input logic w, input logic [31:0] a,
      input logic [3:0] exp);
      @(posedge sys_clk);
      mem_req <= '{1'b1, w, a};
      @(posedge sys_clk);
      mem_req.valid <= 1'b0;
      #1 check({28'h0, ext_abort, mem_pass, data_abort, address_exception},
         {28'h0, exp});
   endtask
   task automatic set_status(input logic [31:0] d);
      @(posedge sys_clk);
      status_wr <= '{1'b1, 1'b0, d};
      @(posedge sys_clk);
      status_wr.valid <= 1'b0;
      #1 check({27'h0, active_mode}, {27'h0, d[4:0]});
   endtask
   // pulse an exception request, expect flush only on a trap, link value and mode
   task automatic exc(input logic [4:0] tm, input logic t,
      input logic [31:0] pc, input logic [31:0] link);
      @(posedge sys_clk);
      exc_req <= '{1'b1, tm, t, pc};
      @(posedge sys_clk);
      exc_req.valid <= 1'b0;
      #1 check({link_register[31:1], stream_flush}, {link[31:1], t});
      check({27'h0, active_mode}, {27'h0, tm});
   endtask
   task automatic finish_test;
      $display("comparisons %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   // ==========================================================
   // scenarios
   // ==========================================================
   initial begin
      repeat (6) @(posedge sys_clk);
      rst_n <= 1'b1;
      reg_rd(ADDR_STATUS_WORD);
      check(rd, RESET_STATUS);
      reg_rd(4'hF);
      check(rd, 32'h0);
      mem_chk(1'b1, 32'h00000010, 4'b0100);
      // enter each legacy mode, ending in user
      for (int i = 1; i < 5; i++) begin
         m = 5'(i & 3);
         set_status({24'h0, 3'b110, m});
         check(pc_view & 32'h0C000000, 32'h0C000000);
         reg_rd(ADDR_BANK);
         check(rd & 32'h19, (m == 5'h0) ? 32'h01 :
            (m == 5'h1) ? 32'h19 : 32'h11);
         if (m != 5'h0) set_status(32'hD3);
      end
      set_status(32'hF0000000);
      check(current_status_word, 32'hF00000C0);
      mem_chk(1'b1, 32'h0000001F, 4'b0010);
      mem_chk(1'b1, 32'h00000020, 4'b0100);
      mem_chk(1'b0, 32'h00000000, 4'b0100);
      mem_chk(1'b1, 32'h04000000, 4'b1100);
      reg_wr(ADDR_CTRL, 32'h1);
      mem_chk(1'b0, 32'h04000000, 4'b1001);
      mem_chk(1'b1, 32'h03FFFFFC, 4'b0100);
      mem_chk(1'b1, 32'h00000000, 4'b0010);
      // events, mask and level interrupt
      reg_rd(ADDR_EVENTS);
      check(rd & 32'h3, 32'h3);
      check({31'h0, irq}, 32'h0);
      reg_wr(ADDR_MASK, 32'h1);
      reg_rd(ADDR_MASK);
      check({rd[31:1], irq}, 32'h1);
      reg_wr(ADDR_EVENTS, 32'h1F);
      reg_rd(ADDR_EVENTS);
      check({rd[31:1], irq}, 32'h0);
      exc(MODE_SVC32, 1'b1, 32'hFFFFFFFF, 32'h03FFFFFC);
      check(saved_status_word, 32'hF00000C0);
      exc(MODE_UND32, 1'b0, 32'h12345678, 32'h12345678);
      @(posedge sys_clk);
      barrier_req <= 1'b1;
      @(posedge sys_clk);
      barrier_req <= 1'b0;
      ranged_barrier_req <= 1'b1;
      #1 check({31'h0, stream_flush}, 32'h1);
      @(posedge sys_clk);
      ranged_barrier_req <= 1'b0;
      #1 check({31'h0, stream_flush}, 32'h1);
      finish_test();
   end
   initial begin
      #100000;
      mismatches++;
      finish_test();
   end
endmodule
bind legacy_26bit_mode_control legacy_mode_chk chk (.*);
`default_nettype wire
